// ==== touch_pkg.sv ====
// Constants and types shared by the touch output and burst scheduler
package touch_pkg;
    // Option byte zero fields
    localparam int OUT_MODE_LSB = 0;
    localparam int THRESH_LSB = 4;
    localparam int PWR_MODE_LSB = 6;
    // Option byte one fields
    localparam int XFER_RATE_BIT = 1;
    localparam int PERIOD_SEL_BIT = 2;
    localparam logic [7:0] OPT_RESET = 8'h00;
    // Timing
    localparam int CLK_HZ = 100_000_000;
    localparam int SAMPLE_LONG_MS = 20;
    localparam int SAMPLE_SHORT_MS = 10;
    localparam int SAMPLE_LONG_CYCLES = SAMPLE_LONG_MS * (CLK_HZ / 1000);
    localparam int LATCH_SHORT_S = 3;
    localparam int LATCH_LONG_S = 30;
    localparam int LP_GAP_ZOOM = 4;
    localparam int LP_GAP_EXTREME = 16;
    localparam int XFER_SLOW_KHZ = 125;
    localparam int XFER_FAST_KHZ = 250;
    localparam int XFER_SLOW_DIV = CLK_HZ / (XFER_SLOW_KHZ * 1000 * 2);
    localparam int XFER_FAST_DIV = CLK_HZ / (XFER_FAST_KHZ * 1000 * 2);
    // Sample periods per second at the long period
    localparam int PERIODS_PER_S = 1000 / SAMPLE_LONG_MS;

    typedef enum logic [1:0] {
        OUT_ACTIVE, OUT_TOGGLE, OUT_LATCH_SHORT, OUT_LATCH_LONG
    } out_mode_t;
    typedef enum logic [1:0] {
        PWR_LOW_ZOOM, PWR_NORMAL, PWR_EXTREME_ZOOM, PWR_EXTREME
    } pwr_mode_t;
    typedef enum logic [1:0] {
        TH_STD_PROX, TH_STD_TOUCH, TH_SENS_PROX, TH_SENS_TOUCH
    } thresh_t;
endpackage

// ==== sample_tick.sv ====
// Sample period tick generator with selectable period length
`timescale 1ns/1ps
`default_nettype none
module sample_tick
    import touch_pkg::*;
#(
    parameter int LONG_CYCLES = SAMPLE_LONG_CYCLES
)(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Control
    input wire logic short_period,
    // Tick
    output logic tick
);
    logic [31:0] count_reg;
    logic [31:0] limit;

    // Short period halves the count limit, so each sample period is half as long
    assign limit = short_period ? 32'(LONG_CYCLES / 2) : 32'(LONG_CYCLES);

    always_ff @(posedge mclk)
    begin
        if (reset || count_reg >= limit - 32'h1)
        begin
            count_reg <= 32'h0;
        end
        else
        begin
            count_reg <= count_reg + 32'h1;
        end
    end

    always_ff @(posedge mclk)
    begin
        tick <= !reset && (count_reg >= limit - 32'h1);
    end
endmodule
`default_nettype wire

// ==== xfer_clock.sv ====
// Charge transfer clock divider
`timescale 1ns/1ps
`default_nettype none
module xfer_clock
    import touch_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Control
    input wire logic fast,
    input wire logic run,
    // Transfer clock
    output logic xfer_clk
);
    logic [15:0] div_reg;
    logic [15:0] half;

    assign half = fast ? 16'(XFER_FAST_DIV) : 16'(XFER_SLOW_DIV);

    always_ff @(posedge mclk)
    begin
        if (reset || !run)
        begin
            div_reg <= 16'h0;
            xfer_clk <= 1'b0;
        end
        else if (div_reg >= half - 16'h1)
        begin
            div_reg <= 16'h0;
            xfer_clk <= !xfer_clk;
        end
        else
        begin
            div_reg <= div_reg + 16'h1;
        end
    end
endmodule
`default_nettype wire

// ==== touch_output_and_burst_scheduler.sv ====
// Detect output modes and burst scheduling for a single touch channel
// Summary of operation
// - Output mode comes from option byte zero bits one and zero.
// - Mode codes: 00 active, 01 toggle, 10 short latch, 11 long latch.
// - Detect pin high reports actuation, low otherwise.
// - After rising, the pin stays high at least the minimum high time.
// - Active mode: pin follows detection.
// - Toggle mode: each new actuation outside the minimum high time inverts the pin.
// - Short latch: high at least three seconds, longer while detection lasts.
// - Long latch: pin falls thirty seconds after detection ends.
// - Long latch: new actuation restarts the countdown from its end.
// - Threshold level comes from option byte zero bits five and four.
// - Threshold codes: standard prox, standard touch, sensitive prox, sensitive touch.
// - Sensitivity rank: sensitive prox, standard prox, sensitive touch, standard touch.
// - Power mode comes from option byte zero bits seven and six.
// - Power codes: low zoom, normal, extreme zoom, extreme.
// - Normal mode bursts every sample period.
// - Low power zoom idle bursts every fifth sample period.
// - Zoom modes burst every period on activity until reentry delay passes.
// - Extreme zoom idle bursts every seventeenth sample period.
// - Extreme mode always idles sixteen periods between bursts.
// - Option byte one bit one selects 125 or 250 kHz transfer.
// - Option byte one bit two selects 20 or 10 ms period.
// - Bit two low 20 ms, high 10 ms; bit one low 125, high 250 kHz.
// - Short period makes all power mode intervals run twice as fast.
`timescale 1ns/1ps
`default_nettype none
module touch_output_and_burst_scheduler
#(
    parameter int MIN_HIGH_PERIODS = 4,
    parameter int REENTRY_PERIODS = 50,
    parameter int SAMPLE_CYCLES = touch_pkg::SAMPLE_LONG_CYCLES,
    parameter int PER_SECOND = touch_pkg::PERIODS_PER_S
)(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Option bytes
    input wire logic [7:0] option_byte_zero,
    input wire logic [7:0] option_byte_one,
    // Sensing core
    input wire logic detect_flag,
    input wire logic burst_done,
    // Outputs
    output logic detect_output_pin,
    output logic burst_start,
    output logic burst_active,
    output logic charge_transfer_clk,
    output logic [1:0] detect_threshold_level,
    output logic [1:0] threshold_rank,
    output logic zoom_awake
);
    import touch_pkg::*;

    out_mode_t out_mode;
    pwr_mode_t pwr_mode;
    thresh_t thresh;
    logic short_period;
    logic fast_xfer;
    logic tick;
    logic xfer_clk;
    logic [4:0] gap_reg;
    logic [4:0] gap_target;
    logic [15:0] reentry_reg;
    logic det_reg;
    logic prev_seen;
    logic fresh;
    logic zoom_mode;
    logic [15:0] min_high_reg;
    logic [15:0] latch_reg;
    logic [15:0] latch_short;
    logic [15:0] latch_long;

    // Threshold rank, 0 = most sensitive
    function automatic logic [1:0] rank_of(input thresh_t t);
        case (t)
            TH_SENS_PROX: rank_of = 2'h0;
            TH_STD_PROX: rank_of = 2'h1;
            TH_SENS_TOUCH: rank_of = 2'h2;
            default: rank_of = 2'h3;
        endcase
    endfunction

    assign out_mode = out_mode_t'(option_byte_zero[OUT_MODE_LSB +: 2]);
    assign thresh = thresh_t'(option_byte_zero[THRESH_LSB +: 2]);
    assign pwr_mode = pwr_mode_t'(option_byte_zero[PWR_MODE_LSB +: 2]);
    assign short_period = option_byte_one[PERIOD_SEL_BIT];
    assign fast_xfer = option_byte_one[XFER_RATE_BIT];
    assign zoom_mode = pwr_mode == PWR_LOW_ZOOM || pwr_mode == PWR_EXTREME_ZOOM;

    // Latch times counted in sample periods; with the short period each
    // second holds twice as many periods
    assign latch_short = short_period ? 16'(2 * LATCH_SHORT_S * PER_SECOND)
                                      : 16'(LATCH_SHORT_S * PER_SECOND);
    assign latch_long = short_period ? 16'(2 * LATCH_LONG_S * PER_SECOND)
                                     : 16'(LATCH_LONG_S * PER_SECOND);

    sample_tick #(.LONG_CYCLES(SAMPLE_CYCLES)) u_tick (
        .mclk(mclk),
        .reset(reset),
        .short_period(short_period),
        .tick(tick)
    );

    xfer_clock u_xfer (
        .mclk(mclk),
        .reset(reset),
        .fast(fast_xfer),
        .run(burst_active),
        .xfer_clk(xfer_clk)
    );

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            detect_threshold_level <= 2'h0;
            threshold_rank <= 2'h0;
            charge_transfer_clk <= 1'b0;
        end
        else
        begin
            detect_threshold_level <= thresh;
            threshold_rank <= rank_of(thresh);
            charge_transfer_clk <= xfer_clk;
        end
    end

    // Idle gap for the current mode and activity
    always_comb
    begin
        case (pwr_mode)
            PWR_NORMAL: gap_target = 5'h0;
            PWR_LOW_ZOOM: gap_target = zoom_awake ? 5'h0 : 5'(LP_GAP_ZOOM);
            PWR_EXTREME_ZOOM: gap_target = zoom_awake ? 5'h0 : 5'(LP_GAP_EXTREME);
            default: gap_target = 5'(LP_GAP_EXTREME);
        endcase
    end

    // Burst scheduling on sample ticks
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            gap_reg <= 5'h0;
            burst_start <= 1'b0;
        end
        else
        begin
            burst_start <= 1'b0;
            if (tick)
            begin
                if (gap_reg >= gap_target)
                begin
                    gap_reg <= 5'h0;
                    burst_start <= 1'b1;
                end
                else
                begin
                    gap_reg <= gap_reg + 5'h1;
                end
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            burst_active <= 1'b0;
        end
        else if (burst_start)
        begin
            burst_active <= 1'b1;
        end
        else if (burst_done)
        begin
            burst_active <= 1'b0;
        end
    end

    // Zoom wake on activity; modes without zoom never wake
    always_ff @(posedge mclk)
    begin
        if (reset || !zoom_mode)
        begin
            zoom_awake <= 1'b0;
            reentry_reg <= 16'h0;
        end
        else if (burst_done && burst_active && detect_flag)
        begin
            zoom_awake <= 1'b1;
            reentry_reg <= 16'(REENTRY_PERIODS);
        end
        else if (tick && zoom_awake && !det_reg)
        begin
            if (reentry_reg <= 16'h1)
            begin
                zoom_awake <= 1'b0;
                reentry_reg <= 16'h0;
            end
            else
            begin
                reentry_reg <= reentry_reg - 16'h1;
            end
        end
    end

    // Detection sampled once per completed burst
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            det_reg <= 1'b0;
        end
        else if (burst_done && burst_active)
        begin
            det_reg <= detect_flag;
        end
    end

    // One-cycle new actuation, rising edge of sampled detection
    assign fresh = det_reg && !prev_seen;

    // Output state: latch timers run on sample ticks
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            detect_output_pin <= 1'b0;
            min_high_reg <= 16'h0;
            latch_reg <= 16'h0;
            prev_seen <= 1'b0;
        end
        else
        begin
            prev_seen <= det_reg;
            if (tick && min_high_reg != 16'h0)
            begin
                min_high_reg <= min_high_reg - 16'h1;
            end
            if (tick && latch_reg != 16'h0)
            begin
                latch_reg <= latch_reg - 16'h1;
            end
            case (out_mode)
                OUT_ACTIVE:
                begin
                    if (det_reg && !detect_output_pin)
                    begin
                        detect_output_pin <= 1'b1;
                        min_high_reg <= 16'(MIN_HIGH_PERIODS);
                    end
                    else if (!det_reg && min_high_reg == 16'h0)
                    begin
                        detect_output_pin <= 1'b0;
                    end
                end
                OUT_TOGGLE:
                begin
                    if (fresh && !detect_output_pin)
                    begin
                        detect_output_pin <= 1'b1;
                        min_high_reg <= 16'(MIN_HIGH_PERIODS);
                    end
                    else if (fresh && min_high_reg == 16'h0)
                    begin
                        detect_output_pin <= 1'b0;
                    end
                end
                OUT_LATCH_SHORT:
                begin
                    if (fresh && !detect_output_pin)
                    begin
                        detect_output_pin <= 1'b1;
                        min_high_reg <= 16'(MIN_HIGH_PERIODS);
                        latch_reg <= latch_short;
                    end
                    else if (!det_reg && latch_reg == 16'h0 && min_high_reg == 16'h0)
                    begin
                        detect_output_pin <= 1'b0;
                    end
                end
                default:
                begin
                    if (det_reg)
                    begin
                        // Countdown held full while detection lasts
                        latch_reg <= latch_long;
                        if (!detect_output_pin)
                        begin
                            detect_output_pin <= 1'b1;
                            min_high_reg <= 16'(MIN_HIGH_PERIODS);
                        end
                    end
                    else if (latch_reg == 16'h0 && min_high_reg == 16'h0)
                    begin
                        detect_output_pin <= 1'b0;
                    end
                end
            endcase
        end
    end

    chk_active_follows: assert property (@(posedge mclk) disable iff (reset)
        (out_mode == OUT_ACTIVE && $stable(out_mode) && det_reg && !detect_output_pin)
        |=> detect_output_pin)
        else $error("active mode output did not rise");
    chk_min_high_time: assert property (@(posedge mclk) disable iff (reset)
        ($fell(detect_output_pin)) |-> $past(min_high_reg) == 16'h0)
        else $error("output fell before minimum high time");
    chk_normal_burst: assert property (@(posedge mclk) disable iff (reset)
        (pwr_mode == PWR_NORMAL && $stable(pwr_mode) && tick) |=> burst_start)
        else $error("normal mode missed a burst");
    chk_extreme_gap: assert property (@(posedge mclk) disable iff (reset)
        (pwr_mode == PWR_EXTREME && burst_start) |-> $past(gap_reg) == 5'(LP_GAP_EXTREME))
        else $error("extreme mode burst without sixteen idle periods");
    chk_gap_bound: assert property (@(posedge mclk) disable iff (reset)
        gap_reg <= 5'(LP_GAP_EXTREME))
        else $error("idle gap beyond sixteen periods");
    chk_wake_on_det: assert property (@(posedge mclk) disable iff (reset)
        (burst_done && burst_active && detect_flag) |=> zoom_awake == $past(zoom_mode))
        else $error("zoom wake state wrong after activity");
    chk_long_restart: assert property (@(posedge mclk) disable iff (reset)
        (out_mode == OUT_LATCH_LONG && $stable(out_mode) && det_reg)
        |=> latch_reg == latch_long && detect_output_pin)
        else $error("long latch countdown not restarted");
    chk_rank_map: assert property (@(posedge mclk) disable iff (reset)
        $stable(thresh) && thresh == TH_SENS_PROX |=> threshold_rank == 2'h0)
        else $error("threshold rank wrong");
    chk_thresh_out: assert property (@(posedge mclk) disable iff (reset)
        $stable(thresh) |=> detect_threshold_level == $past(thresh))
        else $error("threshold level not passed");
endmodule
`default_nettype wire

// ==== sense_core_model.sv ====
// Behavioural sensing core that answers each burst request
`timescale 1ns/1ps
`default_nettype none
module sense_core_model #(
    parameter int FAST_DELAY = 10,
    parameter int SLOW_DELAY = 1200
)(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Bench control
    input wire logic touch,
    input wire logic slow,
    // Burst handshake
    input wire logic burst_start,
    output var logic burst_done,
    output var logic detect_flag
);
    int cnt;

    initial
    begin
        burst_done = 1'b0;
        detect_flag = 1'b0;
        cnt = 0;
    end

    // Flag only means something with the done pulse, so it wanders otherwise
    // Rising edge so it never races the bench's falling-edge inputs
    always @(posedge mclk)
    begin
        burst_done <= 1'b0;
        detect_flag <= ~detect_flag;
        if (reset)
        begin
            cnt <= 0;
            detect_flag <= 1'b0;
        end
        else if (burst_start === 1'b1)
            cnt <= slow ? SLOW_DELAY : FAST_DELAY;
        else if (cnt == 1)
        begin
            cnt <= 0;
            burst_done <= 1'b1;
            detect_flag <= touch;
        end
        else if (cnt != 0)
            cnt <= cnt - 1;
    end
endmodule
`default_nettype wire

// ==== touch_output_and_burst_scheduler_tb.sv ====
// Self-checking bench for the touch output and burst scheduler
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin bad_count++; \
    $display("[ERR] %0t: got %0h expected %0h", $time, (a), (e)); end end
module touch_output_and_burst_scheduler_tb;
    import touch_pkg::*;
    // Shortened counts keep the run small
    localparam int SC = 100;
    localparam int PS = 2;
    localparam int MH = 4;
    localparam int RE = 3;
    logic mclk;
    logic reset;
    logic [7:0] o0;
    logic [7:0] o1;
    logic touch;
    logic slow;
    logic detect_flag;
    logic burst_done;
    logic detect_output_pin;
    logic burst_start;
    logic burst_active;
    logic charge_transfer_clk;
    logic [1:0] detect_threshold_level;
    logic [1:0] threshold_rank;
    logic zoom_awake;
    int bad_count = 0;
    int checked = 0;
    logic [1:0] rank_exp [4] = '{2'h1, 2'h3, 2'h0, 2'h2};

    touch_output_and_burst_scheduler #(.MIN_HIGH_PERIODS(MH), .REENTRY_PERIODS(RE),
        .SAMPLE_CYCLES(SC), .PER_SECOND(PS)) dut_u (
        .mclk(mclk), .reset(reset), .option_byte_zero(o0), .option_byte_one(o1),
        .detect_flag(detect_flag), .burst_done(burst_done),
        .detect_output_pin(detect_output_pin), .burst_start(burst_start),
        .burst_active(burst_active), .charge_transfer_clk(charge_transfer_clk),
        .detect_threshold_level(detect_threshold_level),
        .threshold_rank(threshold_rank), .zoom_awake(zoom_awake));

    sense_core_model core_u (.mclk(mclk), .reset(reset), .touch(touch), .slow(slow),
        .burst_start(burst_start), .burst_done(burst_done), .detect_flag(detect_flag));

    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic end_sim();
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic tick(int n);
        repeat (n) @(negedge mclk);
    endtask

    // Option bytes are static, so each setting gets a fresh reset
    task automatic cfg(logic [7:0] a, logic [7:0] b);
        @(negedge mclk);
        o0 = a;
        o1 = b;
        touch = 1'b0;
        slow = 1'b0;
        reset = 1'b1;
        tick(2);
        reset = 1'b0;
        tick(2);
    endtask

    function automatic logic pick(int w);
        case (w)
            0: return burst_start;
            1: return detect_output_pin;
            default: return charge_transfer_clk;
        endcase
    endfunction

    task automatic wait_for(int w, logic lvl, output int n);
        n = 0;
        while (pick(w) !== lvl)
        begin
            if (n == 4000)
            begin
                bad_count++;
                $display("[ERR] %0t: wait ran out", $time);
                end_sim();
            end
            tick(1);
            n++;
        end
    endtask

    // Distance in cycles between two burst starts
    task automatic gap(int exp);
        int n;
        wait_for(0, 1'b1, n);
        tick(1);
        wait_for(0, 1'b1, n);
        `CHK(n + 1, exp)
    endtask

    task automatic s_thresh();
        for (int c = 0; c < 4; c++)
        begin
            cfg({2'b01, c[1:0], 4'h0}, 8'h00);
            `CHK(detect_threshold_level, c[1:0])
            `CHK(threshold_rank, rank_exp[c])
        end
    endtask

    task automatic s_power();
        cfg(8'h40, 8'h00);
        gap(SC);
        cfg(8'h40, 8'h04);
        gap(SC / 2);
        cfg(8'h00, 8'h00);
        gap(5 * SC);
        cfg(8'h00, 8'h04);
        gap(5 * SC / 2);
        cfg(8'h80, 8'h00);
        gap(17 * SC);
        cfg(8'hc0, 8'h00);
        touch = 1'b1;
        gap(17 * SC);
        gap(17 * SC);
        `CHK(zoom_awake, 1'b0)
    endtask

    task automatic s_zoom(logic [7:0] a, int low);
        cfg(a, 8'h00);
        touch = 1'b1;
        tick(2 * low + 100);
        gap(SC);
        `CHK(zoom_awake, 1'b1)
        touch = 1'b0;
        tick(SC * (RE + 3));
        gap(low);
        `CHK(zoom_awake, 1'b0)
    endtask

    task automatic s_active();
        int n;
        cfg(8'h40, 8'h00);
        touch = 1'b1;
        tick(3 * SC);
        `CHK(detect_output_pin, 1'b1)
        touch = 1'b0;
        tick((MH + 2) * SC);
        `CHK(detect_output_pin, 1'b0)
        touch = 1'b1;
        wait_for(1, 1'b1, n);
        touch = 1'b0;
        tick((MH - 1) * SC);
        `CHK(detect_output_pin, 1'b1)
        tick(3 * SC);
        `CHK(detect_output_pin, 1'b0)
    endtask

    task automatic s_toggle();
        cfg(8'h41, 8'h00);
        touch = 1'b1;
        tick(3 * SC);
        `CHK(detect_output_pin, 1'b1)
        touch = 1'b0;
        tick(6 * SC);
        `CHK(detect_output_pin, 1'b1)
        touch = 1'b1;
        tick(3 * SC);
        `CHK(detect_output_pin, 1'b0)
        tick(3 * SC);
        `CHK(detect_output_pin, 1'b0)
    endtask

    task automatic s_short();
        int n;
        cfg(8'h42, 8'h00);
        touch = 1'b1;
        wait_for(1, 1'b1, n);
        touch = 1'b0;
        tick(3 * PS * SC - 50);
        `CHK(detect_output_pin, 1'b1)
        tick(200);
        `CHK(detect_output_pin, 1'b0)
        touch = 1'b1;
        wait_for(1, 1'b1, n);
        tick(10 * SC);
        `CHK(detect_output_pin, 1'b1)
        touch = 1'b0;
        tick(2 * SC);
        `CHK(detect_output_pin, 1'b0)
    endtask

    task automatic s_long();
        int n;
        cfg(8'h43, 8'h00);
        touch = 1'b1;
        wait_for(1, 1'b1, n);
        tick(2 * SC);
        touch = 1'b0;
        tick(3000);
        `CHK(detect_output_pin, 1'b1)
        touch = 1'b1;
        tick(2 * SC);
        touch = 1'b0;
        tick(30 * PS * SC - 200);
        `CHK(detect_output_pin, 1'b1)
        tick(600);
        `CHK(detect_output_pin, 1'b0)
    endtask

    // Long bursts so a whole half period of the transfer clock fits
    task automatic s_xfer(logic [7:0] b, int div);
        int n;
        cfg(8'hc0, b);
        slow = 1'b1;
        wait_for(2, 1'b1, n);
        wait_for(2, 1'b0, n);
        `CHK(n, div)
    endtask

    initial
    begin
        o0 = 8'h00;
        o1 = 8'h00;
        touch = 1'b0;
        slow = 1'b0;
        reset = 1'b1;
        tick(20);
        reset = 1'b0;
        tick(1);
        `CHK(detect_output_pin, 1'b0)
        `CHK(burst_active, 1'b0)
        `CHK(charge_transfer_clk, 1'b0)
        s_thresh();
        s_power();
        s_zoom(8'h00, 5 * SC);
        s_zoom(8'h80, 17 * SC);
        s_active();
        s_toggle();
        s_short();
        s_long();
        s_xfer(8'h00, touch_pkg::XFER_SLOW_DIV);
        s_xfer(8'h02, touch_pkg::XFER_FAST_DIV);
        end_sim();
    end
endmodule
`default_nettype wire
